// File: verilog/hbs_pkg.sv
// How it works
// - fourth bus request ORed with primary
// - all data grants ORed into one
// - ORed data grant tracks processor tenures
// - data bus split high/low, bit zero MSB
// - eight parity lines sampled in, driven out
// - busy sampled every cycle, whoever masters
// - busy driven only after qualified cache grant
// - shared flush-done line, drive low only
// - global-transaction output negated when we master
// - reset async assert, synchronous release
// - address tenure starts only after address grant
// - bus request driven as output normally
// - cache data grant starts our data tenure
package hbs_pkg;
  localparam int unsigned HALF_W      = 32;
  localparam int unsigned PAR_W       = 8;
  localparam int unsigned RST_SYNC_N  = 2;
  localparam int unsigned HRST_MIN_CYC = 16;
  localparam int unsigned DATA_BEATS  = 4;
  localparam int unsigned BEAT_CNT_W  = 3;
  localparam logic        NEG_LVL     = 1'b1;

  typedef enum logic [2:0] {
    HBS_IDLE   = 3'b000,
    HBS_REQ    = 3'b001,
    HBS_ADDR   = 3'b010,
    HBS_DWAIT  = 3'b011,
    HBS_DATA   = 3'b100
  } hbs_state_t;

  // even parity, one bit per byte lane over all eight lanes; used on both directions
  function automatic logic [PAR_W-1:0] hbs_parity(input logic [2*HALF_W-1:0] d);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ^d[(2*HALF_W-1-8*i) -: 8];
    end
    return p;
  endfunction : hbs_parity
endpackage : hbs_pkg

// File: verilog/hbs_reset_sync.sv
module hbs_reset_sync
  import hbs_pkg::*;
#(
  parameter int unsigned STAGES = RST_SYNC_N
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  output logic      resetn_o
);
  logic [STAGES-1:0] sync_r;

  // assert at once, release only on a clock edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[STAGES-2:0], 1'b1};
    end
  end

  assign resetn_o = sync_r[STAGES-1];
endmodule : hbs_reset_sync

// File: verilog/hbs_host_bus.sv
module hbs_host_bus
  import hbs_pkg::*;
#(
  parameter int unsigned BEATS = DATA_BEATS
) (
  // clock and hard reset (processor clock, active low)
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  // processor bus requests and data grants, active low
  input  wire logic               proc_bus_request_n_i,
  input  wire logic               fourth_proc_bus_request_n_i,
  input  wire logic               proc_data_grant_n_i,
  input  wire logic               second_proc_data_grant_n_i,
  input  wire logic               third_proc_data_grant_n_i,
  input  wire logic               fourth_proc_data_grant_n_i,
  // arbiter to cache
  input  wire logic               cache_address_grant_n_i,
  input  wire logic               cache_data_grant_n_i,
  // cache bus request pin (two-way, normally output)
  input  wire logic               cache_bus_request_n_i,
  output logic                    cache_bus_request_n_o,
  output logic                    cache_bus_request_oe_o,
  // data bus busy pin
  input  wire logic               data_bus_busy_n_i,
  output logic                    data_bus_busy_n_o,
  output logic                    data_bus_busy_oe_o,
  // data bus halves and parity
  input  wire logic [HALF_W-1:0]  data_high_half_i,
  input  wire logic [HALF_W-1:0]  data_low_half_i,
  output logic      [HALF_W-1:0]  data_high_half_o,
  output logic      [HALF_W-1:0]  data_low_half_o,
  output logic                    data_oe_o,
  input  wire logic [PAR_W-1:0]   data_parity_lines_i,
  output logic      [PAR_W-1:0]   data_parity_lines_o,
  // shared flush-done line, open drain
  input  wire logic               flush_complete_shared_n_i,
  output logic                    flush_complete_shared_n_o,
  output logic                    flush_complete_shared_oe_o,
  // global transaction
  output logic                    global_transaction_n_o,
  // cache core side
  input  wire logic               master_req_i,
  input  wire logic [2*HALF_W-1:0] wr_data_i,
  input  wire logic               flush_done_i,
  output logic                    beat_ack_o,
  output logic                    xfer_done_o,
  output logic      [2*HALF_W-1:0] rd_data_o,
  output logic                    rd_valid_o,
  output logic                    parity_err_o,
  output logic                    proc_req_o,
  output logic                    proc_data_owner_o,
  output logic                    bus_busy_o,
  output logic                    peer_flush_done_o
);
  logic                  rst_n;
  hbs_state_t            state_r;
  hbs_state_t            state_nxt;
  logic [BEAT_CNT_W-1:0] beat_r;
  logic                  proc_req_c;
  logic                  proc_dg_c;
  logic                  last_beat_c;
  logic [2*HALF_W-1:0]   rd_word_c;

  hbs_reset_sync #(
    .STAGES (RST_SYNC_N)
  ) u_rst (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .resetn_o  (rst_n)
  );

  // active low: any low request or grant is an assertion
  assign proc_req_c = ~(proc_bus_request_n_i & fourth_proc_bus_request_n_i);
  assign proc_dg_c  = ~(proc_data_grant_n_i & second_proc_data_grant_n_i
                        & third_proc_data_grant_n_i & fourth_proc_data_grant_n_i);
  assign last_beat_c = (beat_r == BEAT_CNT_W'(BEATS - 1));
  assign rd_word_c   = {data_high_half_i, data_low_half_i};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      HBS_IDLE: begin
        if (master_req_i) begin
          state_nxt = HBS_REQ;
        end
      end
      HBS_REQ: begin
        if (!cache_address_grant_n_i) begin
          state_nxt = HBS_ADDR;
        end
      end
      HBS_ADDR: begin
        state_nxt = HBS_DWAIT;
      end
      HBS_DWAIT: begin
        // qualified: grant low and no processor still holding busy
        if (!cache_data_grant_n_i && data_bus_busy_n_i) begin
          state_nxt = HBS_DATA;
        end
      end
      HBS_DATA: begin
        if (last_beat_c) begin
          state_nxt = HBS_IDLE;
        end
      end
      default: begin
        state_nxt = HBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HBS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      beat_r <= '0;
    end else if (state_r == HBS_DATA) begin
      beat_r <= last_beat_c ? '0 : beat_r + 1'b1;
    end else begin
      beat_r <= '0;
    end
  end

  // request pin is an output once out of reset; driven high on the edge the address grant is seen
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cache_bus_request_n_o  <= NEG_LVL;
      cache_bus_request_oe_o <= 1'b0;
    end else begin
      cache_bus_request_oe_o <= 1'b1;
      cache_bus_request_n_o  <= ~(state_nxt == HBS_REQ);
    end
  end

  // busy driven only in our data tenure, input otherwise
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      data_bus_busy_n_o  <= NEG_LVL;
      data_bus_busy_oe_o <= 1'b0;
    end else begin
      data_bus_busy_oe_o <= (state_nxt == HBS_DATA);
      data_bus_busy_n_o  <= ~(state_nxt == HBS_DATA);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      data_high_half_o    <= '0;
      data_low_half_o     <= '0;
      data_parity_lines_o <= '0;
      data_oe_o           <= 1'b0;
      beat_ack_o          <= 1'b0;
      xfer_done_o         <= 1'b0;
    end else begin
      data_oe_o   <= (state_nxt == HBS_DATA);
      beat_ack_o  <= (state_nxt == HBS_DATA);
      xfer_done_o <= (state_r == HBS_DATA) && last_beat_c;
      if (state_nxt == HBS_DATA) begin
        data_high_half_o    <= wr_data_i[2*HALF_W-1 -: HALF_W];
        data_low_half_o     <= wr_data_i[HALF_W-1:0];
        data_parity_lines_o <= hbs_parity(wr_data_i);
      end
    end
  end

  // incoming data sampled on any processor data grant outside our own data tenure
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o    <= '0;
      rd_valid_o   <= 1'b0;
      parity_err_o <= 1'b0;
    end else begin
      rd_valid_o   <= proc_dg_c && (state_r != HBS_DATA);
      parity_err_o <= 1'b0;
      if (proc_dg_c && (state_r != HBS_DATA)) begin
        rd_data_o    <= rd_word_c;
        parity_err_o <= (hbs_parity(rd_word_c) != data_parity_lines_i);
      end
    end
  end

  // open drain: only ever pull low
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      flush_complete_shared_n_o  <= 1'b0;
      flush_complete_shared_oe_o <= 1'b0;
      peer_flush_done_o          <= 1'b0;
    end else begin
      flush_complete_shared_n_o  <= 1'b0;
      flush_complete_shared_oe_o <= flush_done_i;
      peer_flush_done_o          <= ~flush_complete_shared_n_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      global_transaction_n_o <= NEG_LVL;
      proc_req_o             <= 1'b0;
      proc_data_owner_o      <= 1'b0;
      bus_busy_o             <= 1'b0;
    end else begin
      global_transaction_n_o <= NEG_LVL;
      proc_req_o             <= proc_req_c;
      proc_data_owner_o      <= proc_dg_c;
      bus_busy_o             <= ~data_bus_busy_n_i;
    end
  end
endmodule : hbs_host_bus

// File: tb/hbs_host_bus_checker.sv
module hbs_host_bus_checker (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic proc_bus_request_n_i,
  input wire logic fourth_proc_bus_request_n_i,
  input wire logic cache_address_grant_n_i,
  input wire logic cache_data_grant_n_i,
  input wire logic cache_bus_request_n_o,
  input wire logic data_bus_busy_n_i,
  input wire logic data_bus_busy_n_o,
  input wire logic data_bus_busy_oe_o,
  input wire logic data_oe_o,
  input wire logic flush_done_i,
  input wire logic flush_complete_shared_n_o,
  input wire logic flush_complete_shared_oe_o,
  input wire logic global_transaction_n_o,
  input wire logic xfer_done_o,
  input wire logic proc_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  glob_negated_a: assert property (global_transaction_n_o)
    else $error("global low");
  busy_grant_a: assert property ($rose(data_bus_busy_oe_o) |->
    $past(!cache_data_grant_n_i && data_bus_busy_n_i)) else $error("busy without grant");
  busy_own_a: assert property (data_bus_busy_oe_o |-> data_oe_o && !data_bus_busy_n_o)
    else $error("busy outside tenure");
  busy_drop_a: assert property ($fell(data_oe_o) |-> !data_bus_busy_oe_o)
    else $error("busy held");
  req_or_a: assert property (proc_req_o ==
    $past(!(proc_bus_request_n_i && fourth_proc_bus_request_n_i))) else $error("req merge");
  req_release_a: assert property (!cache_bus_request_n_o && !cache_address_grant_n_i |=>
    cache_bus_request_n_o) else $error("req held");
  beats_span_a: assert property ($rose(data_oe_o) |-> data_oe_o[*4] ##1
    !data_oe_o && xfer_done_o) else $error("tenure length");
  flush_drive_a: assert property (flush_complete_shared_oe_o == $past(flush_done_i) &&
    (!flush_complete_shared_oe_o || !flush_complete_shared_n_o)) else $error("flush line");
  cover property ($rose(data_oe_o));
  cover property ($rose(flush_complete_shared_oe_o));
  cover property ($fell(cache_bus_request_n_o));
endmodule : hbs_host_bus_checker

bind hbs_host_bus hbs_host_bus_checker hbs_host_bus_checker_inst (.*);

// File: tb/hbs_arbiter_model.sv
module hbs_arbiter_model (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic bus_req_n_i,
  input  wire logic slow_i,
  output logic      addr_grant_n_o,
  output logic      data_grant_n_o,
  output logic      busy_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  // same clock as the cache, so grants change only on shared edges
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_grant_n_o <= 1'b1;
      data_grant_n_o <= 1'b1;
      busy_n_o <= 1'b1;
      cnt_r <= 3'h0;
    end else begin
      addr_grant_n_o <= !(!bus_req_n_i && addr_grant_n_o && cnt_r == 3'h0);
      if (!addr_grant_n_o) begin
        data_grant_n_o <= 1'b0;
        // slow mode: another master still owns the data bus for three cycles
        busy_n_o <= !slow_i;
        cnt_r <= 3'h6;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
        data_grant_n_o <= (cnt_r == 3'h1);
        busy_n_o <= busy_n_o | (cnt_r == 3'h4);
      end
    end
  end
endmodule : hbs_arbiter_model

// File: tb/hbs_host_bus_bench.sv
module hbs_host_bus_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i, resetn_i, master_req_i, flush_done_i, slow, busy_m, parity_err_o;
  logic        proc_bus_request_n_i, fourth_proc_bus_request_n_i, proc_data_grant_n_i;
  logic        second_proc_data_grant_n_i, third_proc_data_grant_n_i, fourth_proc_data_grant_n_i;
  logic        cache_bus_request_n_o, cache_bus_request_oe_o, data_bus_busy_n_o, data_oe_o;
  logic        flush_complete_shared_n_o, flush_complete_shared_oe_o, global_transaction_n_o;
  logic        data_bus_busy_oe_o, beat_ack_o, xfer_done_o, rd_valid_o, proc_req_o;
  logic        bus_busy_o, peer_flush_done_o, cache_address_grant_n_i, cache_data_grant_n_i;
  logic        proc_data_owner_o;
  logic [1:0]  rq;
  logic [3:0]  g;
  logic [31:0] data_high_half_i, data_low_half_i, data_high_half_o, data_low_half_o;
  logic [7:0]  data_parity_lines_i, data_parity_lines_o, p;
  logic [63:0] wr_data_i, rd_data_o, d;
  logic [64:0] n, notes[$];
  int          mismatches = 0, checked = 0, seed = 21712, dones = 0, k, r;
  // released request and flush pins float to the pull-up level; released busy follows the arbiter model
  wire cache_bus_request_n_i = cache_bus_request_oe_o ? cache_bus_request_n_o : 1'b1;
  wire data_bus_busy_n_i = data_bus_busy_oe_o ? data_bus_busy_n_o : busy_m;
  wire flush_complete_shared_n_i = flush_complete_shared_oe_o ? flush_complete_shared_n_o : 1'b1;
  assign {proc_bus_request_n_i, fourth_proc_bus_request_n_i} = rq;
  assign {proc_data_grant_n_i, second_proc_data_grant_n_i} = g[3:2];
  assign {third_proc_data_grant_n_i, fourth_proc_data_grant_n_i} = g[1:0];
  hbs_host_bus hbs_host_bus_inst (.*);
  hbs_arbiter_model hbs_arbiter_model_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .bus_req_n_i(cache_bus_request_n_i), .slow_i(slow), .busy_n_o(busy_m),
    .addr_grant_n_o(cache_address_grant_n_i), .data_grant_n_o(cache_data_grant_n_i));
  function automatic logic [7:0] par(logic [63:0] v);
    for (int i = 0; i < 8; i++) par[i] = ^v[63-8*i -: 8];
  endfunction : par
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    if (xfer_done_o === 1'b1) dones++;
    if (data_oe_o === 1'b1) begin
      check("drive_data", {data_high_half_o, data_low_half_o}, wr_data_i);
      check("drive_par", data_parity_lines_o, par(wr_data_i));
      check("beat_ack", beat_ack_o, 1);
      check("busy_drive", {data_bus_busy_oe_o, data_bus_busy_n_o}, 2'b10);
    end
    if (rd_valid_o === 1'b1) begin
      check("rd_note", notes.size() > 0, 1);
      check("dg_owner", proc_data_owner_o, 1);
      n = notes.size() > 0 ? notes.pop_front() : '0;
      check("rd_data", rd_data_o, n[63:0]);
      check("par_err", parity_err_o, n[64]);
    end
  end
  initial begin
    {resetn_i, master_req_i, flush_done_i, slow, rq, g} = 10'h03f;
    {data_high_half_i, data_low_half_i, data_parity_lines_i, wr_data_i} = '0;
    // test-port reset is taken as already applied before hard reset
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    repeat (40) begin
      r = $random(seed);
      d = {$random(seed), $random(seed)};
      // roughly one beat in four carries a bad parity bit
      p = par(d) ^ {7'h0, r[7] & r[8]};
      rq <= r[1:0];
      g <= r[6] ? 4'hf : r[5:2];
      {data_high_half_i, data_low_half_i, data_parity_lines_i} <= {d, p};
      if (!r[6] && r[5:2] != 4'hf) notes.push_back({p != par(d), d});
      @(posedge clk_sys_i);
    end
    {rq, g} <= 6'h3f;
    flush_done_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("peer_flush", peer_flush_done_o, 1);
    check("flush_line", flush_complete_shared_n_i, 0);
    @(posedge clk_sys_i);
    flush_done_i <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      slow <= t[0];
      master_req_i <= 1'b1;
      wr_data_i <= {$random(seed), $random(seed)};
      @(posedge clk_sys_i);
      master_req_i <= 1'b0;
      k = 0;
      do begin
        @(negedge clk_sys_i);
        k++;
      end while (xfer_done_o !== 1'b1 && k < 60);
      check("no_timeout", k < 60, 1);
      if (k >= 60) give_verdict();
      check("global_n", global_transaction_n_o, 1);
      @(posedge clk_sys_i);
    end
    repeat (3) @(posedge clk_sys_i);
    check("xfers", dones, 4);
    check("notes_left", notes.size(), 0);
    give_verdict();
  end
endmodule : hbs_host_bus_bench
